// ### host_power_reset_keypad_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module host_power_reset_keypad_sequencer (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic HOST_POWER_SENSE,
  input wire logic KEY_UPPER_RIGHT,
  input wire logic KEY_LOWER_RIGHT,
  input wire logic CFG_WRITE,
  input wire logic [7:0] CFG_ENABLES,
  input wire logic CFG_LEN_VALID,
  input wire logic [7:0] CFG_PULSE_LEN,
  input wire logic BOOT_STORE,
  input wire logic BOOT_VALID,
  input wire logic [7:0] BOOT_ENABLES,
  input wire logic [7:0] BOOT_PULSE_LEN,
  output logic [7:0] SAVED_ENABLES,
  output logic [7:0] SAVED_PULSE_LEN,
  output logic RESET_LINE_OUT,
  output logic RESET_LINE_OE_N,
  output logic POWER_LINE_OUT,
  output logic POWER_LINE_OE_N,
  output logic [2:0] MESSAGE,
  output logic CMD_LOCKOUT,
  output logic SELF_RESTART
);

  typedef struct packed {
    pwr_seq_pkg::state_t state;
    logic [7:0] enables;
    logic [7:0] pulse_len;
    logic [7:0] saved_en;
    logic [7:0] saved_len;
    logic boot_done;
    logic [1:0][pwr_seq_pkg::CNT_W-1:0] hold;
    logic [pwr_seq_pkg::CNT_W-1:0] timer;
    logic [pwr_seq_pkg::CNT_W-1:0] unit_cnt;
    logic [7:0] units;
    logic [2:0] msg;
    logic restart;
  } regs_t;

  localparam logic [31:0] LONG_C = 32'(pwr_seq_pkg::HOLD_LONG_CYC);
  localparam logic [31:0] SHORT_C = 32'(pwr_seq_pkg::HOLD_SHORT_CYC);
  localparam logic [31:0] RST_C = 32'(pwr_seq_pkg::RESET_PULSE_CYC);
  localparam logic [31:0] EXTRA_C = 32'(pwr_seq_pkg::EXTRA_HOLD_CYC);
  localparam logic [31:0] UNIT_C = 32'(pwr_seq_pkg::UNIT_CYC);
  localparam int KEY_UR = 0;
  localparam int KEY_LR = 1;

  regs_t r;
  regs_t next_r;

  logic [1:0] key_held;
  logic [1:0][pwr_seq_pkg::CNT_W-1:0] hold_next;

  assign key_held = {KEY_LOWER_RIGHT, KEY_UPPER_RIGHT};

  // Hold timers saturate at the long threshold and clear on release.
  // They only run while idle: a key still held when a pulse ends counts
  // again from zero, so one long hold can fire a further pulse.
  for (genvar k = 0; k < 2; k++) begin : g_hold
    assign hold_next[k] = (!key_held[k] || r.state != pwr_seq_pkg::ST_IDLE) ? '0
                        : (r.hold[k] == LONG_C) ? r.hold[k]
                        : r.hold[k] + 1;
  end

  always_comb begin
    next_r = r;
    next_r.restart = 1'b0;
    // Boot settings are adopted once after reset and after each restart, then config writes win
    if (!r.boot_done) begin
      next_r.boot_done = 1'b1;
      if (BOOT_VALID) begin
        next_r.enables = BOOT_ENABLES;
        next_r.pulse_len = BOOT_PULSE_LEN;
      end
    end else if (CFG_WRITE && r.state == pwr_seq_pkg::ST_IDLE) begin
      next_r.enables = CFG_ENABLES;
      if (CFG_LEN_VALID) begin
        next_r.pulse_len = CFG_PULSE_LEN;
      end else begin
        next_r.pulse_len = pwr_seq_pkg::DEFAULT_PULSE_UNITS;
      end
    end

    if (BOOT_STORE && r.state == pwr_seq_pkg::ST_IDLE) begin
      next_r.saved_en = r.enables;
      next_r.saved_len = r.pulse_len;
    end

    next_r.hold = hold_next;

    unique case (r.state)
      pwr_seq_pkg::ST_IDLE: begin
        next_r.timer = '0;
        next_r.unit_cnt = '0;
        next_r.units = '0;
        // Reset wins over power-on, which wins over power-off
        if (r.enables[pwr_seq_pkg::BIT_KEYPAD_RESET] && HOST_POWER_SENSE
            && r.hold[KEY_UR] == LONG_C) begin
          next_r.state = pwr_seq_pkg::ST_RST_PULSE;
          next_r.msg = pwr_seq_pkg::MSG_RESET;
        end else if (r.enables[pwr_seq_pkg::BIT_KEYPAD_POWER_ON] && !HOST_POWER_SENSE
            && r.hold[KEY_UR] >= SHORT_C) begin
          next_r.state = pwr_seq_pkg::ST_PON_PULSE;
          next_r.msg = pwr_seq_pkg::MSG_POWER_ON;
        end else if (r.enables[pwr_seq_pkg::BIT_KEYPAD_POWER_OFF] && HOST_POWER_SENSE
            && r.hold[KEY_LR] == LONG_C) begin
          next_r.state = pwr_seq_pkg::ST_POFF_PULSE;
          next_r.msg = pwr_seq_pkg::MSG_POWER_OFF;
        end
      end
      pwr_seq_pkg::ST_RST_PULSE: begin
        // Fixed length; the length byte only shapes power pulses
        next_r.timer = r.timer + 1;
        if (r.timer == RST_C - 1) begin
          next_r.state = pwr_seq_pkg::ST_RESTART;
        end
      end
      pwr_seq_pkg::ST_PON_PULSE, pwr_seq_pkg::ST_POFF_PULSE: begin
        // Pulse length counted in 1/32 s units
        if (r.unit_cnt == UNIT_C - 1) begin
          next_r.unit_cnt = '0;
          next_r.units = r.units + 8'h01;
          if (r.units + 8'h01 >= r.pulse_len) begin
            if (r.state == pwr_seq_pkg::ST_PON_PULSE) begin
              next_r.state = pwr_seq_pkg::ST_RESTART;
            end else if (KEY_LOWER_RIGHT) begin
              next_r.state = pwr_seq_pkg::ST_POFF_EXTRA;
            end else begin
              next_r.state = pwr_seq_pkg::ST_IDLE;
              next_r.msg = pwr_seq_pkg::MSG_NONE;
            end
          end
        end else begin
          next_r.unit_cnt = r.unit_cnt + 1;
        end
      end
      pwr_seq_pkg::ST_POFF_EXTRA: begin
        // Extra drive ends on release or at the limit, whichever comes first
        next_r.timer = r.timer + 1;
        if (!KEY_LOWER_RIGHT || r.timer == EXTRA_C - 1) begin
          next_r.state = pwr_seq_pkg::ST_IDLE;
          next_r.msg = pwr_seq_pkg::MSG_NONE;
        end
      end
      pwr_seq_pkg::ST_RESTART: begin
        // One-cycle restart request; settings survive via the boot copy
        next_r.restart = 1'b1;
        next_r.state = pwr_seq_pkg::ST_IDLE;
        next_r.msg = pwr_seq_pkg::MSG_NONE;
        next_r.boot_done = 1'b0;
        next_r.enables = r.saved_en;
        next_r.pulse_len = r.saved_len;
      end
      default: next_r.state = pwr_seq_pkg::ST_IDLE;
    endcase
  end

  // Synchronous reset returns every field to its power-up value
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      r <= '{
        state: pwr_seq_pkg::ST_IDLE,
        enables: pwr_seq_pkg::ENABLE_RESET_VALUE,
        pulse_len: pwr_seq_pkg::DEFAULT_PULSE_UNITS,
        saved_en: pwr_seq_pkg::ENABLE_RESET_VALUE,
        saved_len: pwr_seq_pkg::DEFAULT_PULSE_UNITS,
        boot_done: 1'b0,
        hold: '0,
        timer: '0,
        unit_cnt: '0,
        units: '0,
        msg: pwr_seq_pkg::MSG_NONE,
        restart: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  logic rst_active;
  logic pwr_active;

  assign rst_active = (r.state == pwr_seq_pkg::ST_RST_PULSE);
  assign pwr_active = (r.state == pwr_seq_pkg::ST_PON_PULSE)
                    || (r.state == pwr_seq_pkg::ST_POFF_PULSE)
                    || (r.state == pwr_seq_pkg::ST_POFF_EXTRA);

  // Enable low means driving; floating otherwise
  assign RESET_LINE_OE_N = !rst_active;
  assign POWER_LINE_OE_N = !pwr_active;

  // Levels come from the enable register, frozen while a pulse runs,
  // so a driven line never changes level mid-pulse
  assign RESET_LINE_OUT = r.enables[pwr_seq_pkg::BIT_RESET_INVERT];
  assign POWER_LINE_OUT = r.enables[pwr_seq_pkg::BIT_POWER_INVERT];
  assign MESSAGE = r.msg;

  // Commands are refused from the end of a reset or power-on pulse until restart
  assign CMD_LOCKOUT = (r.state == pwr_seq_pkg::ST_RESTART);
  assign SELF_RESTART = r.restart;

  assign SAVED_ENABLES = r.saved_en;
  assign SAVED_PULSE_LEN = r.saved_len;
endmodule : host_power_reset_keypad_sequencer
`default_nettype wire

// ### pwr_seq_pkg.sv
`default_nettype none
package pwr_seq_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HOLD_LONG_MS = 4000;
  localparam int unsigned HOLD_SHORT_MS = 250;
  localparam int unsigned RESET_PULSE_MS = 1000;
  localparam int unsigned EXTRA_HOLD_MS = 5000;
  localparam int unsigned UNIT_DIV = 32;
  localparam longint unsigned HOLD_LONG_CYC = longint'(CLK_HZ) * HOLD_LONG_MS / 1000;
  localparam longint unsigned HOLD_SHORT_CYC = longint'(CLK_HZ) * HOLD_SHORT_MS / 1000;
  localparam longint unsigned RESET_PULSE_CYC = longint'(CLK_HZ) * RESET_PULSE_MS / 1000;
  localparam longint unsigned EXTRA_HOLD_CYC = longint'(CLK_HZ) * EXTRA_HOLD_MS / 1000;
  localparam longint unsigned UNIT_CYC = longint'(CLK_HZ) / UNIT_DIV;
  localparam int CNT_W = 32;
  localparam int BIT_RESET_INVERT = 1;
  localparam int BIT_POWER_INVERT = 2;
  localparam int BIT_KEYPAD_RESET = 5;
  localparam int BIT_KEYPAD_POWER_ON = 6;
  localparam int BIT_KEYPAD_POWER_OFF = 7;
  localparam logic [7:0] DEFAULT_PULSE_UNITS = 8'h20;
  localparam logic [7:0] ENABLE_RESET_VALUE = 8'h00;
  localparam logic [2:0] MSG_NONE = 3'h0;
  localparam logic [2:0] MSG_RESET = 3'h1;
  localparam logic [2:0] MSG_POWER_ON = 3'h2;
  localparam logic [2:0] MSG_POWER_OFF = 3'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_RST_PULSE = 6'b00_0010,
    ST_PON_PULSE = 6'b00_0100,
    ST_POFF_PULSE = 6'b00_1000,
    ST_POFF_EXTRA = 6'b01_0000,
    ST_RESTART = 6'b10_0000
  } state_t;
endpackage : pwr_seq_pkg
`default_nettype wire

// ### pwr_seq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_monitor (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic KEY_UPPER_RIGHT,
  input wire logic CFG_WRITE,
  input wire logic [7:0] CFG_ENABLES,
  input wire logic CFG_LEN_VALID,
  input wire logic [7:0] CFG_PULSE_LEN,
  input wire logic BOOT_STORE,
  input wire logic [7:0] SAVED_ENABLES,
  input wire logic [7:0] SAVED_PULSE_LEN,
  input wire logic RESET_LINE_OUT,
  input wire logic RESET_LINE_OE_N,
  input wire logic POWER_LINE_OE_N,
  input wire logic [2:0] MESSAGE,
  input wire logic CMD_LOCKOUT,
  input wire logic SELF_RESTART
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Config is only taken while neither line is driven
  wire idle = RESET_LINE_OE_N && POWER_LINE_OE_N && !CMD_LOCKOUT;
  // The cycle after release or restart adopts the boot image, not a write
  sequence wr_s; CFG_WRITE && !$past(SYS_RST) && !SELF_RESTART && idle; endsequence
  sequence st_s; BOOT_STORE && idle; endsequence
  chk_reset_vals: assert property ($fell(SYS_RST) |-> SAVED_ENABLES == 8'h00 &&
    SAVED_PULSE_LEN == 8'h20 && RESET_LINE_OE_N && POWER_LINE_OE_N) else $error("bad reset state");
  chk_store_en: assert property (wr_s ##1 st_s |=> SAVED_ENABLES == $past(CFG_ENABLES, 2))
    else $error("stored enables wrong");
  chk_store_len: assert property (wr_s ##1 st_s |=> SAVED_PULSE_LEN ==
    ($past(CFG_LEN_VALID, 2) ? $past(CFG_PULSE_LEN, 2) : 8'h20)) else $error("stored length wrong");
  chk_reset_msg: assert property (!RESET_LINE_OE_N |-> MESSAGE == pwr_seq_pkg::MSG_RESET)
    else $error("no reset message");
  chk_level_hold: assert property (!RESET_LINE_OE_N && $past(!RESET_LINE_OE_N) |->
    $stable(RESET_LINE_OUT)) else $error("drive level moved");
  chk_reset_cause: assert property ($fell(RESET_LINE_OE_N) |-> $past(KEY_UPPER_RIGHT, 2))
    else $error("reset pulse without key");
  chk_power_msg: assert property (!POWER_LINE_OE_N |-> MESSAGE == pwr_seq_pkg::MSG_POWER_ON ||
    MESSAGE == pwr_seq_pkg::MSG_POWER_OFF) else $error("no power message");
  chk_restart_one: assert property (SELF_RESTART |->
    ($past(CMD_LOCKOUT) && !CMD_LOCKOUT) ##1 !SELF_RESTART)
    else $error("restart not single");
endmodule : pwr_seq_monitor
bind host_power_reset_keypad_sequencer pwr_seq_monitor pwr_seq_monitor_i (.*);
`default_nettype wire

// ### host_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
  input wire logic power_on,
  input wire logic reset_out,
  input wire logic reset_oe_n,
  input wire logic power_out,
  input wire logic power_oe_n,
  output logic sense,
  output logic reset_wire,
  output logic power_wire
);
  assign sense = power_on;
  // Released lines read as the board pull-up, never the last driven level
  assign reset_wire = reset_oe_n ? 1'b1 : reset_out;
  assign power_wire = power_oe_n ? 1'b1 : power_out;
endmodule : host_board_model
`default_nettype wire

// ### test_host_power_reset_keypad_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_host_power_reset_keypad_sequencer;
  logic REF_CLK = 0, SYS_RST = 1, KEY_UPPER_RIGHT = 0, KEY_LOWER_RIGHT = 0, CFG_WRITE = 0;
  logic CFG_LEN_VALID = 0, BOOT_STORE = 0, BOOT_VALID = 0, power_on = 0;
  logic [7:0] CFG_ENABLES = 0, CFG_PULSE_LEN = 0, BOOT_ENABLES = 0, BOOT_PULSE_LEN = 0;
  logic HOST_POWER_SENSE, RESET_LINE_OUT, RESET_LINE_OE_N, POWER_LINE_OUT, POWER_LINE_OE_N;
  logic [7:0] SAVED_ENABLES, SAVED_PULSE_LEN;
  logic [2:0] MESSAGE;
  logic CMD_LOCKOUT, SELF_RESTART, reset_wire, power_wire;
  logic [7:0] en_tbl [4] = '{8'h20, 8'h40, 8'h80, 8'h06};
  logic [7:0] len_tbl [4] = '{8'h01, 8'hFF, 8'h10, 8'h02};
  // Drive levels {reset, power} that each enable byte selects
  logic [7:0] lvl_tbl [4] = '{8'h00, 8'h00, 8'h00, 8'h03};
  int fail_count = 0;
  int n_checks = 0;
  host_power_reset_keypad_sequencer host_power_reset_keypad_sequencer_i (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .HOST_POWER_SENSE(HOST_POWER_SENSE),
    .KEY_UPPER_RIGHT(KEY_UPPER_RIGHT),
    .KEY_LOWER_RIGHT(KEY_LOWER_RIGHT),
    .CFG_WRITE(CFG_WRITE),
    .CFG_ENABLES(CFG_ENABLES),
    .CFG_LEN_VALID(CFG_LEN_VALID),
    .CFG_PULSE_LEN(CFG_PULSE_LEN),
    .BOOT_STORE(BOOT_STORE),
    .BOOT_VALID(BOOT_VALID),
    .BOOT_ENABLES(BOOT_ENABLES),
    .BOOT_PULSE_LEN(BOOT_PULSE_LEN),
    .SAVED_ENABLES(SAVED_ENABLES),
    .SAVED_PULSE_LEN(SAVED_PULSE_LEN),
    .RESET_LINE_OUT(RESET_LINE_OUT),
    .RESET_LINE_OE_N(RESET_LINE_OE_N),
    .POWER_LINE_OUT(POWER_LINE_OUT),
    .POWER_LINE_OE_N(POWER_LINE_OE_N),
    .MESSAGE(MESSAGE),
    .CMD_LOCKOUT(CMD_LOCKOUT),
    .SELF_RESTART(SELF_RESTART)
  );
  host_board_model host_board_model_i (.power_on(power_on), .reset_out(RESET_LINE_OUT),
    .reset_oe_n(RESET_LINE_OE_N), .power_out(POWER_LINE_OUT), .power_oe_n(POWER_LINE_OE_N),
    .sense(HOST_POWER_SENSE), .reset_wire(reset_wire), .power_wire(power_wire));
  always #4 REF_CLK = ~REF_CLK;
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic store(input logic [7:0] en, input logic lv, input logic [7:0] len);
    @(posedge REF_CLK);
    CFG_WRITE <= 1'b1;
    CFG_ENABLES <= en;
    CFG_LEN_VALID <= lv;
    CFG_PULSE_LEN <= len;
    @(posedge REF_CLK);
    CFG_WRITE <= 1'b0;
    BOOT_STORE <= 1'b1;
    @(posedge REF_CLK);
    BOOT_STORE <= 1'b0;
    @(negedge REF_CLK);
  endtask : store
  // Holds far below any threshold; the lines must stay released throughout
  task automatic hold(input logic up, input logic on, input int n);
    @(posedge REF_CLK);
    power_on <= on;
    KEY_UPPER_RIGHT <= up;
    KEY_LOWER_RIGHT <= !up;
    repeat (n) begin
      @(negedge REF_CLK);
      check({1'b0, MESSAGE, SELF_RESTART, CMD_LOCKOUT, reset_wire, power_wire}, 8'h03);
    end
    @(posedge REF_CLK);
    KEY_UPPER_RIGHT <= 1'b0;
    KEY_LOWER_RIGHT <= 1'b0;
  endtask : hold
  initial begin
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(negedge REF_CLK);
    check(SAVED_ENABLES, 8'h00);
    check(SAVED_PULSE_LEN, 8'h20);
    for (int i = 0; i < 4; i++) begin
      store(en_tbl[i], 1'b1, len_tbl[i]);
      check(SAVED_ENABLES, en_tbl[i]);
      check(SAVED_PULSE_LEN, len_tbl[i]);
      check({6'h00, RESET_LINE_OUT, POWER_LINE_OUT}, lvl_tbl[i]);
      store(8'hE6, 1'b1, 8'h08);
      hold(i[0], i[1], 2000);
    end
    store(8'hE6, 1'b0, 8'h05);
    check(SAVED_ENABLES, 8'hE6);
    check(SAVED_PULSE_LEN, 8'h20);
    // Mid-run reset with a boot image present: settings come back from it
    @(posedge REF_CLK);
    SYS_RST <= 1'b1;
    BOOT_VALID <= 1'b1;
    BOOT_ENABLES <= 8'hA2;
    BOOT_PULSE_LEN <= 8'h11;
    repeat (8) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(negedge REF_CLK);
    check(SAVED_ENABLES, 8'h00);
    check(SAVED_PULSE_LEN, 8'h20);
    @(posedge REF_CLK);
    BOOT_STORE <= 1'b1;
    @(posedge REF_CLK);
    BOOT_STORE <= 1'b0;
    @(negedge REF_CLK);
    check(SAVED_ENABLES, 8'hA2);
    check(SAVED_PULSE_LEN, 8'h11);
    check({6'h00, RESET_LINE_OUT, POWER_LINE_OUT}, 8'h02);
    stop_test();
  end
endmodule : test_host_power_reset_keypad_sequencer
`default_nettype wire
